/* File: spierr_defines.svh */
`ifndef SPIERR_DEFINES_SVH
`define SPIERR_DEFINES_SVH
// ----------------------------------------
// frame geometry
// ----------------------------------------
`define SPIERR_BITS 8
`define SPIERR_CNT_W 4
// capture index of data bit 1 (seventh capture)
`define SPIERR_BIT1_IDX 4'h6
// capture index of the last data bit
`define SPIERR_LAST_IDX 4'h7
`define SPIERR_FULL_CNT 4'h8
// ----------------------------------------
// reset values and master divider
// ----------------------------------------
`define SPIERR_BYTE_RST 8'h00
`define SPIERR_CNT_RST 4'h0
`define SPIERR_HALF_DEF 4
`endif

/* File: spierr_pkg.sv */
package spierr_pkg;
    // master engine states, one-hot
    typedef enum logic [1:0] {
        SPIERR_IDLE = 2'b01,
        SPIERR_RUN = 2'b10
    } spierr_mst_type;
endpackage

/* File: spierr_core.sv */
`timescale 1ns/100ps
`include "spierr_defines.svh"
module spierr_core
    import spierr_pkg::*;
#(
    parameter int HALF_CYCLES = `SPIERR_HALF_DEF
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // link clock from a remote master
    input wire logic sckLink,
    // pins
    input wire logic ssInN,
    input wire logic mosiIn,
    input wire logic misoIn,
    output logic sckOut,
    output logic sckOe,
    output logic mosiOut,
    output logic mosiOe,
    output logic misoOut,
    output logic misoOe,
    // control bits
    input wire logic masterSelectBit,
    input wire logic faultDetectEnable,
    input wire logic errorIrqEnable,
    input wire logic txIrqEnable,
    input wire logic rxIrqEnable,
    input wire logic clkPhase,
    input wire logic clkPolarity,
    input wire logic enableWrData,
    // software access strobes
    input wire logic statusRead,
    input wire logic dataRead,
    input wire logic controlWrite,
    input wire logic txWrite,
    input wire logic [7:0] txData,
    // status
    output logic moduleEnableBit,
    output logic rxFullFlag,
    output logic txEmptyFlag,
    output logic overflowFlag,
    output logic modeFaultFlag,
    output logic [7:0] rxData,
    // requests
    output logic txIrq,
    output logic rxErrIrq
);
    // ----------------------------------------
    // link domain: slave shifter on sckLink
    // ----------------------------------------
    logic [3:0] lnkCnt_ff; // captures so far
    logic [7:0] lnkShift_ff; // incoming bits
    logic [7:0] lnkHold_ff; // finished byte, stable a frame
    logic lnkDoneTgl_ff; // byte finished event
    logic lnkStrbTgl_ff; // bit-1 strobe event
    logic [2:0] lnkOutIdx_ff; // MISO bit index
    logic [7:0] slvTxWord_ff; // clk-side word, frozen in frame

    // select high acts as reset: a deselected slave ignores clocks
    always_ff @(posedge sckLink or posedge ssInN) begin
        if (ssInN) begin
            lnkCnt_ff <= `SPIERR_CNT_RST;
            lnkShift_ff <= `SPIERR_BYTE_RST;
        end else if (lnkCnt_ff == `SPIERR_LAST_IDX) begin
            lnkCnt_ff <= `SPIERR_CNT_RST;
            lnkShift_ff <= `SPIERR_BYTE_RST;
        end else begin
            lnkCnt_ff <= lnkCnt_ff + 4'h1;
            lnkShift_ff <= {lnkShift_ff[6:0], mosiIn};
        end
    end

    // finished byte and the events, toggles for crossing; a deselect must not
    // move a toggle, or the clk side would see a false byte or strobe, so only
    // system reset (link quiet) clears them; lnkCnt_ff at rest gates
    always_ff @(posedge sckLink or posedge sys_rst) begin
        if (sys_rst) begin
            lnkHold_ff <= `SPIERR_BYTE_RST;
            lnkDoneTgl_ff <= 1'b0;
            lnkStrbTgl_ff <= 1'b0;
        end else begin
            if (lnkCnt_ff == `SPIERR_LAST_IDX) begin
                lnkHold_ff <= {lnkShift_ff[6:0], mosiIn};
                lnkDoneTgl_ff <= ~lnkDoneTgl_ff;
            end
            if (lnkCnt_ff == `SPIERR_BIT1_IDX) begin
                lnkStrbTgl_ff <= ~lnkStrbTgl_ff;
            end
        end
    end

    // outgoing bit index advances on the trailing edge
    always_ff @(negedge sckLink or posedge ssInN) begin
        if (ssInN) begin
            lnkOutIdx_ff <= 3'h0;
        end else begin
            lnkOutIdx_ff <= lnkOutIdx_ff + 3'h1;
        end
    end

    // ----------------------------------------
    // pin and toggle synchronisers
    // ----------------------------------------
    logic [1:0] ssSync_ff; // slave select
    logic [1:0] sckSync_ff; // link clock as a level
    logic [1:0] misoSync_ff; // master data input
    logic [1:0] doneSync_ff; // byte event
    logic [1:0] strbSync_ff; // strobe event
    logic doneSeen_ff; // last synced done level
    logic strbSeen_ff; // last synced strobe level
    logic ssPrev_ff; // select one cycle ago
    logic sckPrev_ff; // link clock one cycle ago

    // first stages feed only their second stages
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ssSync_ff <= 2'h3;
            sckSync_ff <= 2'h0;
            misoSync_ff <= 2'h0;
            doneSync_ff <= 2'h0;
            strbSync_ff <= 2'h0;
        end else begin
            ssSync_ff <= {ssSync_ff[0], ssInN};
            sckSync_ff <= {sckSync_ff[0], sckLink};
            misoSync_ff <= {misoSync_ff[0], misoIn};
            doneSync_ff <= {doneSync_ff[0], lnkDoneTgl_ff};
            strbSync_ff <= {strbSync_ff[0], lnkStrbTgl_ff};
        end
    end

    // history for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            doneSeen_ff <= 1'b0;
            strbSeen_ff <= 1'b0;
            ssPrev_ff <= 1'b1;
            sckPrev_ff <= 1'b0;
        end else begin
            doneSeen_ff <= doneSync_ff[1];
            strbSeen_ff <= strbSync_ff[1];
            ssPrev_ff <= ssSync_ff[1];
            sckPrev_ff <= sckSync_ff[1];
        end
    end

    logic ssHigh; // synced select level
    logic ssRise; // select released
    logic ssFall; // select asserted
    logic sckIdle; // link clock at idle level
    logic sckLeave; // link clock leaves idle
    logic sckBack; // link clock returns to idle
    logic isSlave; // enabled slave
    logic isMaster; // enabled master
    assign ssHigh = ssSync_ff[1];
    assign ssRise = ssHigh & ~ssPrev_ff;
    assign ssFall = ~ssHigh & ssPrev_ff;
    assign sckIdle = sckSync_ff[1] == clkPolarity;
    assign sckLeave = ~sckIdle & (sckPrev_ff == clkPolarity);
    assign sckBack = sckIdle & (sckPrev_ff != clkPolarity);
    assign isSlave = moduleEnableBit & ~masterSelectBit;
    assign isMaster = moduleEnableBit & masterSelectBit;

    // ----------------------------------------
    // slave transfer tracking
    // ----------------------------------------
    logic slvActive_ff; // transfer under way
    logic [3:0] slvBack_ff; // returns to idle seen

    // phase 0 opens on select fall, phase 1 on first clock edge
    always_ff @(posedge clk) begin
        if (sys_rst || !isSlave || ssRise) begin
            slvActive_ff <= 1'b0;
            slvBack_ff <= `SPIERR_CNT_RST;
        end else if (!slvActive_ff) begin
            slvBack_ff <= `SPIERR_CNT_RST;
            if (!clkPhase && ssFall) begin
                slvActive_ff <= 1'b1;
            end else if (clkPhase && !ssHigh && sckLeave) begin
                slvActive_ff <= 1'b1;
            end
        end else if (sckBack) begin
            if (slvBack_ff == `SPIERR_LAST_IDX) begin
                slvActive_ff <= 1'b0;
                slvBack_ff <= `SPIERR_CNT_RST;
            end else begin
                slvBack_ff <= slvBack_ff + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // mode fault detection
    // ----------------------------------------
    logic faultCond; // select inconsistent with mode
    logic masterFault; // fault that shuts a master down
    // a phase 0 select pulse counts even with no clocks
    assign faultCond = faultDetectEnable
        & ((isMaster & ~ssHigh) | (isSlave & slvActive_ff & ssRise));
    // master select is only read, so software can still tell the fault's mode
    assign masterFault = faultCond & masterSelectBit;

    // ----------------------------------------
    // master engine, divided from clk
    // ----------------------------------------
    spierr_mst_type mstState_ff; // engine state
    logic [$clog2(HALF_CYCLES+1)-1:0] divCnt_ff; // half period
    logic mstPhase_ff; // high in second half of bit
    logic [3:0] mstCnt_ff; // captures done
    logic [7:0] mstShift_ff; // shift register
    logic mstCap_ff; // bit taken on the leading edge
    logic [7:0] txBuf_ff; // queued byte, loaded by a tx write
    logic mstStart; // load from tx buffer
    logic halfTick; // half period elapsed
    logic mstStrb; // bit-1 capture
    logic mstDone; // byte finished
    assign halfTick = divCnt_ff == ($bits(divCnt_ff))'(HALF_CYCLES - 1);
    assign mstStart = isMaster & ~txEmptyFlag & (mstState_ff == SPIERR_IDLE);
    assign mstStrb = halfTick & ~mstPhase_ff & (mstState_ff == SPIERR_RUN)
        & (mstCnt_ff == `SPIERR_BIT1_IDX);
    assign mstDone = halfTick & mstPhase_ff & (mstState_ff == SPIERR_RUN)
        & (mstCnt_ff == `SPIERR_FULL_CNT);

    // state counter cleared while disabled or on a master fault
    always_ff @(posedge clk) begin
        if (sys_rst || !isMaster || masterFault) begin
            mstState_ff <= SPIERR_IDLE;
            divCnt_ff <= '0;
            mstPhase_ff <= 1'b0;
            mstCnt_ff <= `SPIERR_CNT_RST;
            mstShift_ff <= `SPIERR_BYTE_RST;
            mstCap_ff <= 1'b0;
        end else begin
            unique case (mstState_ff)
                SPIERR_IDLE: begin
                    divCnt_ff <= '0;
                    if (mstStart) begin
                        mstState_ff <= SPIERR_RUN;
                        mstShift_ff <= txBuf_ff;
                        mstCnt_ff <= `SPIERR_CNT_RST;
                    end
                end
                SPIERR_RUN: begin
                    divCnt_ff <= halfTick ? '0 : divCnt_ff + 1'b1;
                    if (halfTick) begin
                        mstPhase_ff <= ~mstPhase_ff;
                        if (!mstPhase_ff) begin // leading edge samples
                            mstCnt_ff <= mstCnt_ff + 4'h1;
                            mstCap_ff <= misoSync_ff[1];
                        end else begin // trailing edge shifts, so MOSI holds over capture
                            mstShift_ff <= {mstShift_ff[6:0], mstCap_ff};
                            if (mstDone) begin
                                mstState_ff <= SPIERR_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // transmit buffer and tx empty flag
    // ----------------------------------------
    logic slvLoad; // slave takes the queued byte
    assign slvLoad = isSlave & ~txEmptyFlag & ~slvActive_ff & ssHigh;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txBuf_ff <= `SPIERR_BYTE_RST;
        end else if (txWrite) begin
            txBuf_ff <= txData;
        end
    end

    // slave word only changes while deselected, so the link sees it stable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slvTxWord_ff <= `SPIERR_BYTE_RST;
        end else if (slvLoad) begin
            slvTxWord_ff <= txBuf_ff;
        end
    end

    // a buffer move or a disabled module sets; a write clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txEmptyFlag <= 1'b1;
        end else if (mstStart || slvLoad || masterFault || !moduleEnableBit) begin
            txEmptyFlag <= 1'b1;
        end else if (txWrite) begin
            txEmptyFlag <= 1'b0;
        end
    end

    // ----------------------------------------
    // receive path, overflow and rx full
    // ----------------------------------------
    logic byteDone; // a byte reached the receiver
    logic bit1Strb; // bit-1 capture strobe
    logic [7:0] byteIn; // that byte
    logic rxArm_ff; // status seen with full set
    logic ovfArm_ff; // status seen for overflow
    logic ovfSet; // overflow raised this cycle
    assign byteDone = isSlave ? (doneSync_ff[1] ^ doneSeen_ff) : mstDone;
    assign bit1Strb = isSlave ? (strbSync_ff[1] ^ strbSeen_ff) : mstStrb;
    // the last master bit still sits in the capture stage when the byte ends
    assign byteIn = isSlave ? lnkHold_ff : {mstShift_ff[6:0], mstCap_ff};
    assign ovfSet = bit1Strb & rxFullFlag;

    // lost bytes never touch the held byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxData <= `SPIERR_BYTE_RST;
        end else if (byteDone && !overflowFlag && !ovfSet) begin
            rxData <= byteIn;
        end
    end

    // two-step clear arming
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxArm_ff <= 1'b0;
            ovfArm_ff <= 1'b0;
        end else begin
            if (statusRead) begin
                rxArm_ff <= rxFullFlag;
                ovfArm_ff <= overflowFlag;
            end else if (dataRead) begin
                rxArm_ff <= 1'b0;
                ovfArm_ff <= 1'b0;
            end
        end
    end

    // a byte landing on the clearing read keeps the flag set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxFullFlag <= 1'b0;
        end else if (byteDone && !overflowFlag && !ovfSet) begin
            rxFullFlag <= 1'b1;
        end else if (dataRead && rxArm_ff) begin
            rxFullFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overflowFlag <= 1'b0;
        end else if (ovfSet) begin
            overflowFlag <= 1'b1;
        end else if (dataRead && ovfArm_ff) begin
            overflowFlag <= 1'b0;
        end
    end

    // ----------------------------------------
    // mode fault flag and module enable
    // ----------------------------------------
    logic faultArm_ff; // status seen with fault set, no new fault

    // any fault during the sequence spoils the clear
    always_ff @(posedge clk) begin
        if (sys_rst || faultCond) begin
            faultArm_ff <= 1'b0;
        end else if (statusRead) begin
            faultArm_ff <= modeFaultFlag;
        end else if (controlWrite) begin
            faultArm_ff <= 1'b0;
        end
    end

    // enable off only blocks setting, never clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeFaultFlag <= 1'b0;
        end else if (faultCond) begin
            modeFaultFlag <= 1'b1;
        end else if (controlWrite && faultArm_ff) begin
            modeFaultFlag <= 1'b0;
        end
    end

    // only a master fault forces the module off; slaves keep running
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            moduleEnableBit <= 1'b0;
        end else if (masterFault) begin
            moduleEnableBit <= 1'b0;
        end else if (controlWrite) begin
            moduleEnableBit <= enableWrData;
        end
    end

    // ----------------------------------------
    // pins and requests
    // ----------------------------------------
    // mode comes from master select; enables drop with the module
    assign sckOe = isMaster;
    assign mosiOe = isMaster;
    assign misoOe = isSlave & ~ssHigh;
    assign sckOut = clkPolarity ^ mstPhase_ff;
    assign mosiOut = mstShift_ff[7];
    assign misoOut = slvTxWord_ff[3'h7 - lnkOutIdx_ff];
    assign txIrq = txEmptyFlag & txIrqEnable & moduleEnableBit;
    assign rxErrIrq = (rxFullFlag & rxIrqEnable)
        | (errorIrqEnable & (overflowFlag | modeFaultFlag));

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ovf_on_strobe: assert property (@(posedge clk) disable iff (sys_rst)
        bit1Strb && rxFullFlag |=> overflowFlag)
        else $error("overflow not raised at strobe");
    a_rx_kept: assert property (@(posedge clk) disable iff (sys_rst)
        overflowFlag |=> $stable(rxData))
        else $error("held byte changed during overflow");
    a_ovf_clear: assert property (@(posedge clk) disable iff (sys_rst)
        statusRead && overflowFlag ##1 dataRead && !statusRead && !ovfSet
        |=> !overflowFlag)
        else $error("overflow not cleared");
    a_err_irq: assert property (@(posedge clk) disable iff (sys_rst)
        errorIrqEnable && (overflowFlag || modeFaultFlag) |-> rxErrIrq)
        else $error("error request missing");
    a_master_fault: assert property (@(posedge clk) disable iff (sys_rst)
        masterFault |=> !moduleEnableBit && txEmptyFlag
        && mstState_ff == SPIERR_IDLE && !sckOe)
        else $error("master fault side effects missing");
    a_fault_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !faultDetectEnable && !modeFaultFlag |=> !modeFaultFlag)
        else $error("fault set while detection off");
    a_miso_float: assert property (@(posedge clk) disable iff (sys_rst)
        ssHigh |-> !misoOe)
        else $error("MISO driven while deselected");
    a_slave_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        faultCond && !masterSelectBit && !controlWrite |=> moduleEnableBit)
        else $error("slave fault disabled module");
    a_tx_irq: assert property (@(posedge clk) disable iff (sys_rst)
        txIrq |-> txEmptyFlag && moduleEnableBit)
        else $error("tx request without cause");
    a_tx_clear: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(txEmptyFlag) |-> $past(txWrite))
        else $error("tx empty cleared without write");
    c_overflow: cover property (@(posedge clk) disable iff (sys_rst) $rose(overflowFlag));
    c_master_fault: cover property (@(posedge clk) disable iff (sys_rst) masterFault);
    c_slave_byte: cover property (@(posedge clk) disable iff (sys_rst)
        isSlave && byteDone && !overflowFlag);
    c_fault_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(modeFaultFlag));
endmodule

/* File: spierr_remote.sv */
`timescale 1ns/100ps
// ----------------------------------------
// remote party: a master toward the slave, a slave toward the master
// ----------------------------------------
module spierr_remote (
    // link toward the block
    output logic sckLink,
    output logic ssInN,
    output logic mosiIn,
    output logic misoIn,
    // pins from the block
    input wire logic sckOut,
    input wire logic sckOe,
    input wire logic mosiOut,
    input wire logic misoOut
);
    logic [7:0] slaveWord; // byte sent back while the block is master
    logic [7:0] seenMosi; // bits taken from the block as master
    logic [7:0] seenMiso; // bits taken from the block as slave
    initial begin
        sckLink = 1'b0;
        ssInN = 1'b1;
        mosiIn = 1'b0;
        slaveWord = 8'hA5;
        seenMosi = 8'h00;
        seenMiso = 8'h00;
    end
    // msb first; rotate so the word is whole again after a byte
    assign misoIn = slaveWord[7];
    // change on the trailing edge so the synced bit settles before capture
    always @(negedge sckOut) begin
        if (sckOe) begin
            slaveWord <= {slaveWord[6:0], slaveWord[7]};
        end
    end
    // capture on the leading edge
    always @(posedge sckOut) begin
        if (sckOe) begin
            seenMosi <= {seenMosi[6:0], mosiOut};
        end
    end
    // select level, used for master-side contention
    task automatic hold(input logic level);
        ssInN = level;
    endtask
    // one framed exchange at 32 ns; the clock stands still outside it
    task automatic frame(input logic [7:0] b, input int nClk);
        int i;
        ssInN = 1'b0;
        #20;
        for (i = 0; i < nClk; i++) begin
            mosiIn = b[7 - i];
            #16 sckLink = 1'b1;
            // the slave moves MISO on the falling edge, so it is settled here
            seenMiso = {seenMiso[6:0], misoOut};
            #16 sckLink = 1'b0;
        end
        #40;
        // a released line must not keep its last value
        mosiIn = ~mosiIn;
        ssInN = 1'b1;
        #40;
    endtask
endmodule

/* File: spierr_core_tb.sv */
`timescale 1ns/100ps
module spierr_core_tb;
    import spierr_pkg::*;
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    logic clk = 1'b0, sys_rst = 1'b1;
    logic sckLink, ssInN, mosiIn, misoIn, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
    logic masterSelectBit = 1'b0, faultDetectEnable = 1'b1, errorIrqEnable = 1'b0;
    logic txIrqEnable = 1'b0, rxIrqEnable = 1'b1, clkPhase = 1'b0, clkPolarity = 1'b0;
    logic enableWrData = 1'b0, statusRead = 1'b0, dataRead = 1'b0, controlWrite = 1'b0;
    logic txWrite = 1'b0;
    logic [7:0] txData = 8'h00, rxData;
    logic moduleEnableBit, rxFullFlag, txEmptyFlag, overflowFlag, modeFaultFlag;
    logic txIrq, rxErrIrq;
    int n_fail = 0, comparisons = 0, k;
    always #2 clk = ~clk;
    spierr_core #(.HALF_CYCLES(4)) uut (.clk(clk), .sys_rst(sys_rst), .sckLink(sckLink),
        .ssInN(ssInN), .mosiIn(mosiIn), .misoIn(misoIn), .sckOut(sckOut), .sckOe(sckOe),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe),
        .masterSelectBit(masterSelectBit), .faultDetectEnable(faultDetectEnable),
        .errorIrqEnable(errorIrqEnable), .txIrqEnable(txIrqEnable), .rxIrqEnable(rxIrqEnable),
        .clkPhase(clkPhase), .clkPolarity(clkPolarity), .enableWrData(enableWrData),
        .statusRead(statusRead), .dataRead(dataRead), .controlWrite(controlWrite),
        .txWrite(txWrite), .txData(txData), .moduleEnableBit(moduleEnableBit),
        .rxFullFlag(rxFullFlag), .txEmptyFlag(txEmptyFlag), .overflowFlag(overflowFlag),
        .modeFaultFlag(modeFaultFlag), .rxData(rxData), .txIrq(txIrq), .rxErrIrq(rxErrIrq));
    spierr_remote rmt (.sckLink(sckLink), .ssInN(ssInN), .mosiIn(mosiIn), .misoIn(misoIn),
        .sckOut(sckOut), .sckOe(sckOe), .mosiOut(mosiOut), .misoOut(misoOut));
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task automatic give_up(input int lim);
        if (k >= lim) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    // one-cycle software strobes {status, data, control, tx}, then settle
    task automatic strobe(input logic [3:0] sel);
        {statusRead, dataRead, controlWrite, txWrite} = sel;
        step();
        {statusRead, dataRead, controlWrite, txWrite} = 4'h0;
        step();
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // slave receive, request without module enable
    task automatic t_slave_rx;
        enableWrData = 1'b1;
        strobe(4'h2);
        txData = 8'h96;
        strobe(4'h1);
        check(txEmptyFlag, 1'b1);
        rmt.frame(8'h3C, 8);
        for (k = 0; k < 50 && rxFullFlag !== 1'b1; k++) step();
        give_up(50);
        check(rxData, 8'h3C);
        check(rmt.seenMiso, 8'h96);
        check(modeFaultFlag, 1'b0);
        check(misoOe, 1'b0);
        enableWrData = 1'b0;
        strobe(4'h2);
        check(rxErrIrq, 1'b1);
        enableWrData = 1'b1;
        strobe(4'h2);
    endtask
    // unread byte overrun, dropped bytes, two-step clear
    task automatic t_overflow;
        rmt.frame(8'hC3, 8);
        check(overflowFlag, 1'b1);
        rxIrqEnable = 1'b0;
        step();
        check(rxErrIrq, 1'b0);
        errorIrqEnable = 1'b1;
        step();
        check(rxErrIrq, 1'b1);
        rmt.frame(8'h99, 8);
        check(rxData, 8'h3C);
        statusRead = 1'b1;
        step();
        check(overflowFlag, 1'b1);
        {statusRead, dataRead} = 2'h1;
        step();
        dataRead = 1'b0;
        check({overflowFlag, rxFullFlag}, 2'h0);
        check(rxErrIrq, 1'b0);
        strobe(4'h8);
        check(overflowFlag, 1'b0);
    endtask
    // slave select faults by phase, enable gating, clear sequence
    task automatic t_fault_slave;
        rmt.frame(8'h00, 0);
        check(modeFaultFlag, 1'b1);
        check({moduleEnableBit, rxErrIrq}, 2'h3);
        faultDetectEnable = 1'b0;
        strobe(4'h8);
        check(modeFaultFlag, 1'b1);
        strobe(4'h2);
        check(modeFaultFlag, 1'b0);
        rmt.frame(8'h00, 0);
        check(modeFaultFlag, 1'b0);
        faultDetectEnable = 1'b1;
        clkPhase = 1'b1;
        rmt.frame(8'h00, 0);
        check(modeFaultFlag, 1'b0);
        clkPhase = 1'b0;
    endtask
    // master byte, queued byte, contention mid-transfer
    task automatic t_master;
        masterSelectBit = 1'b1;
        txIrqEnable = 1'b1;
        strobe(4'h2);
        check({sckOe, mosiOe, misoOe}, 3'h6);
        check(txIrq, 1'b1);
        txData = 8'h5A;
        strobe(4'h1);
        check(txEmptyFlag, 1'b1);
        for (k = 0; k < 200 && rxFullFlag !== 1'b1; k++) step();
        give_up(200);
        check(rxData, 8'hA5);
        check(rmt.seenMosi, 8'h5A);
        txData = 8'h11;
        strobe(4'h1);
        txData = 8'h22;
        txWrite = 1'b1;
        step();
        txWrite = 1'b0;
        check(txEmptyFlag, 1'b0);
        rmt.hold(1'b0);
        for (k = 0; k < 50 && modeFaultFlag !== 1'b1; k++) step();
        give_up(50);
        step();
        check({moduleEnableBit, txEmptyFlag, sckOe, mosiOe}, 4'h4);
        check({sckOut, txIrq, rxErrIrq}, 3'h1);
        rmt.hold(1'b1);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) step();
        sys_rst = 1'b0;
        check({moduleEnableBit, txEmptyFlag, rxFullFlag, overflowFlag, modeFaultFlag}, 5'h08);
        t_slave_rx();
        t_overflow();
        t_fault_slave();
        t_master();
        report_and_stop();
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule
